/* mtf_pkg.sv */
// constants for the memory and temperature fault status block
// assumes a 32-bit APB slave with word-aligned registers
package mtf_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_MAIN_STATUS   = 8'h01;
  localparam logic [7:0] IDX_SUPPLY_STATUS = 8'h02;
  localparam logic [7:0] IDX_MEMTEMP       = 8'h03;
  localparam logic [7:0] IDX_CONTROL       = 8'h10;
  localparam logic [7:0] IDX_INT_STATUS    = 8'h11;
  localparam logic [7:0] IDX_INT_MASK      = 8'h12;
  localparam logic [7:0] IDX_USER_BASE     = 8'h14;
  localparam int         USER_REG_COUNT    = 4;

  // ==========================================================
  // memory_temp_fault_status fields
  localparam int BIT_FACTORY_FAULT = 7;
  localparam int BIT_USER_FAULT    = 6;
  localparam int BIT_INTEGRITY     = 5;
  localparam int BIT_NV_BUSY       = 4;
  localparam int BIT_TEMP_FAULT    = 2;
  localparam logic [7:0] MEMTEMP_STICKY = 8'hE4;
  localparam logic [7:0] MEMTEMP_RESET  = 8'h00;

  // main status summary position
  localparam int BIT_MAIN_SUMMARY = 4;

  // supply_fault_status fields
  localparam int            SUPPLY_W         = 5;
  localparam logic [7:0]    SUPPLY_BIT_MAP_0 = 8'h00;
  localparam int            SUPPLY_POS_VCC   = 7;

  // control register fields
  localparam int BIT_CTRL_LOCK     = 0;
  localparam int BIT_CTRL_REPORT   = 1;
  localparam int BIT_CTRL_NV_START = 2;

  // interrupt status / mask fields
  localparam int INT_W            = 6;
  localparam int INT_FACTORY      = 0;
  localparam int INT_USER         = 1;
  localparam int INT_INTEGRITY    = 2;
  localparam int INT_TEMP         = 3;
  localparam int INT_NV_DONE      = 4;
  localparam int INT_SUPPLY       = 5;

  // ==========================================================
  // timing
  localparam int CLK_MHZ                  = 25;
  localparam int NV_WRITE_TIME_US         = 100;
  localparam int NV_WRITE_CYCLES          = NV_WRITE_TIME_US * CLK_MHZ;
  localparam int SUPPLY_RECOVERY_TIME_US  = 1000;
  localparam int SUPPLY_RECOVERY_CYCLES   = SUPPLY_RECOVERY_TIME_US * CLK_MHZ;

  typedef enum logic [0:0] {NV_IDLE, NV_WRITING} nv_state_t;

endpackage : mtf_pkg

/* integrity_if.sv */
// carries the user-writable registers to the integrity checker
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface integrity_if #(
  parameter int N = 4,
  parameter int W = 8
);
  logic [W-1:0] regs [N];
  logic         enable;
  logic         mismatch;

  modport owner   (output regs, output enable, input mismatch);
  modport audit   (input regs, input enable, output mismatch);
endinterface : integrity_if

/* integrity_check.sv */
// detection code over user-writable registers, compared to the stored one
// assumes enable stays high once set until reset
`timescale 1ns/10ps
module integrity_check
  import mtf_pkg::*;
#(
  parameter int N = 4,
  parameter int W = 8
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  integrity_if.audit   bus
);

  // ==========================================================
  // detection code
  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [W-1:0] data);
    logic [7:0] c;
    c = crc;
    for (int i = W - 1; i >= 0; i--) begin
      c = (c[7] ^ data[i]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8_step

  logic [7:0] code_now;
  always_comb begin
    code_now = 8'hFF;
    for (int k = 0; k < N; k++) begin
      code_now = crc8_step(code_now, bus.regs[k]);
    end
  end

  // ==========================================================
  // capture at enable, compare afterwards
  logic       enable_q;
  logic       armed_q;
  logic [7:0] stored_q;
  logic       mismatch_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= 1'b0;
      armed_q  <= 1'b0;
      stored_q <= 8'h00;
    end else begin
      enable_q <= bus.enable;
      if (bus.enable && !enable_q) begin
        stored_q <= code_now;
        armed_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mismatch_q <= 1'b0;
    end else begin
      mismatch_q <= armed_q && (code_now != stored_q);
    end
  end

  assign bus.mismatch = mismatch_q;

endmodule : integrity_check

/* memory_temp_fault_status.sv */
// memory and temperature fault status bank with APB register access
// assumes fault inputs synchronous to pclk; frame_sent is a one-cycle pulse
`timescale 1ns/10ps
module memory_temp_fault_status
  import mtf_pkg::*;
#(
  parameter int ADDR_W          = 10,
  parameter int USER_N          = USER_REG_COUNT,
  parameter int NV_CYCLES       = NV_WRITE_CYCLES,
  parameter int RECOVERY_CYCLES = SUPPLY_RECOVERY_CYCLES
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire logic                factory_array_fault,
  input  wire logic                user_array_fault,
  input  wire logic                over_temp,
  input  wire logic                under_temp,
  input  wire logic [SUPPLY_W-1:0] supply_fault_in,
  input  wire logic                frame_sent,
  input  wire logic [7:0]          frame_fault_field,
  output logic                     mem_temp_summary_flag,
  output logic                     irq
);

  // ==========================================================
  // address decode helpers
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a[ADDR_W-1:2] == (ADDR_W-2)'(idx);
  endfunction : hit

  function automatic logic user_hit(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:2] >= (ADDR_W-2)'(IDX_USER_BASE)) &&
           (a[ADDR_W-1:2] <  (ADDR_W-2)'(IDX_USER_BASE) + (ADDR_W-2)'(USER_N));
  endfunction : user_hit

  // ==========================================================
  // state
  logic [7:0]          memtemp_q;
  logic [7:0]          supply_q;
  logic                lock_q;
  logic                report_off_q;
  logic [INT_W-1:0]    int_status_q;
  logic [INT_W-1:0]    int_mask_q;
  logic [7:0]          user_q [USER_N];
  nv_state_t           nv_state_q;
  logic [$clog2(NV_CYCLES+1)-1:0]       nv_cnt_q;
  logic [$clog2(RECOVERY_CYCLES+1)-1:0] rcv_cnt_q;
  logic                nv_done;
  logic                supply_pending_clr_q;

  integrity_if #(.N(USER_N), .W(8)) integ ();

  integrity_check #(.N(USER_N), .W(8)) u_integrity (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (integ.audit)
  );

  // ==========================================================
  // APB handshake: setup cycle prepares answer, access completes
  logic setup_ph;
  logic access_done;
  logic wr_en;
  logic rd_en;
  assign setup_ph    = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_en       = access_done && pwrite && !pslverr;
  assign rd_en       = access_done && !pwrite && !pslverr;

  logic        mapped;
  logic [31:0] rd_mux;
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    if (hit(paddr, IDX_MAIN_STATUS)) begin
      rd_mux[BIT_MAIN_SUMMARY] = mem_temp_summary_flag;
    end else if (hit(paddr, IDX_SUPPLY_STATUS)) begin
      rd_mux[7:0] = supply_q;
    end else if (hit(paddr, IDX_MEMTEMP)) begin
      rd_mux[7:0] = memtemp_q;
    end else if (hit(paddr, IDX_CONTROL)) begin
      rd_mux[BIT_CTRL_LOCK]   = lock_q;
      rd_mux[BIT_CTRL_REPORT] = report_off_q;
    end else if (hit(paddr, IDX_INT_STATUS)) begin
      rd_mux[INT_W-1:0] = int_status_q;
    end else if (hit(paddr, IDX_INT_MASK)) begin
      rd_mux[INT_W-1:0] = int_mask_q;
    end else if (user_hit(paddr)) begin
      rd_mux[7:0] = user_q[paddr[$clog2(USER_N)+1:2]];
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph && !mapped;
      if (setup_ph && !pwrite) begin
        prdata <= mapped ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // control register: lock is set-only until reset
  logic ctrl_wr;
  logic nv_start;
  assign ctrl_wr  = wr_en && hit(paddr, IDX_CONTROL) && pstrb[0];
  assign nv_start = ctrl_wr && pwdata[BIT_CTRL_NV_START];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q       <= 1'b0;
      report_off_q <= 1'b0;
    end else if (ctrl_wr) begin
      lock_q       <= lock_q | pwdata[BIT_CTRL_LOCK];
      report_off_q <= pwdata[BIT_CTRL_REPORT];
    end
  end

  // ==========================================================
  // user-writable registers
  genvar g;
  generate
    for (g = 0; g < USER_N; g++) begin : g_user
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          user_q[g] <= 8'h00;
        end else if (wr_en && pstrb[0] && hit(paddr, IDX_USER_BASE + 8'(g))) begin
          user_q[g] <= pwdata[7:0];
        end
      end
      assign integ.regs[g] = user_q[g];
    end
  endgenerate

  assign integ.enable = lock_q;

  // ==========================================================
  // user nonvolatile write sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_state_q <= NV_IDLE;
      nv_cnt_q   <= '0;
    end else begin
      case (nv_state_q)
        NV_IDLE: begin
          if (nv_start) begin
            nv_state_q <= NV_WRITING;
            nv_cnt_q   <= ($bits(nv_cnt_q))'(NV_CYCLES - 1);
          end
        end
        NV_WRITING: begin
          if (nv_cnt_q == '0) begin
            nv_state_q <= NV_IDLE;
          end else begin
            nv_cnt_q <= nv_cnt_q - 1'b1;
          end
        end
        default: nv_state_q <= NV_IDLE;
      endcase
    end
  end
  assign nv_done = (nv_state_q == NV_WRITING) && (nv_cnt_q == '0);

  // ==========================================================
  // memory / temperature fault register
  logic       memtemp_rd;
  logic [7:0] mt_set;
  logic [7:0] mt_clr;
  assign memtemp_rd = rd_en && hit(paddr, IDX_MEMTEMP);

  always_comb begin
    mt_set = 8'h00;
    mt_set[BIT_FACTORY_FAULT] = factory_array_fault;
    mt_set[BIT_USER_FAULT]    = user_array_fault;
    mt_set[BIT_INTEGRITY]     = integ.mismatch;
    mt_set[BIT_TEMP_FAULT]    = over_temp || under_temp;
    mt_clr = 8'h00;
    if (memtemp_rd) begin
      mt_clr = MEMTEMP_STICKY;
    end
    if (frame_sent) begin
      mt_clr = mt_clr | (frame_fault_field & MEMTEMP_STICKY);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memtemp_q <= MEMTEMP_RESET;
    end else begin
      // set wins over clear; busy is a live level
      memtemp_q <= ((memtemp_q & ~mt_clr) | mt_set) & MEMTEMP_STICKY;
      memtemp_q[BIT_NV_BUSY] <= (nv_state_q == NV_IDLE) ? nv_start : !nv_done;
    end
  end

  // ==========================================================
  // supply faults with shared recovery timer
  logic supply_rd;
  logic supply_any;
  assign supply_rd  = rd_en && hit(paddr, IDX_SUPPLY_STATUS);
  assign supply_any = |supply_fault_in;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcv_cnt_q <= '0;
    end else if (supply_any) begin
      rcv_cnt_q <= ($bits(rcv_cnt_q))'(RECOVERY_CYCLES);
    end else if (rcv_cnt_q != '0) begin
      rcv_cnt_q <= rcv_cnt_q - 1'b1;
    end
  end

  logic [7:0] sup_set;
  assign sup_set = {supply_fault_in[SUPPLY_W-1], 3'b000, supply_fault_in[SUPPLY_W-2:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_q             <= SUPPLY_BIT_MAP_0;
      supply_pending_clr_q <= 1'b0;
    end else begin
      if (supply_any) begin
        supply_q             <= supply_q | sup_set;
        supply_pending_clr_q <= 1'b0;
      end else if (rcv_cnt_q == '0) begin
        // report-off: clear on expiry; otherwise also wait for a read
        if (report_off_q || supply_pending_clr_q || supply_rd) begin
          supply_q             <= SUPPLY_BIT_MAP_0;
          supply_pending_clr_q <= 1'b0;
        end
      end else if (supply_rd) begin
        supply_pending_clr_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // interrupt status (write one to clear) and mask
  logic [INT_W-1:0] int_ev;
  logic [INT_W-1:0] int_clr;
  always_comb begin
    int_ev = '0;
    int_ev[INT_FACTORY]   = factory_array_fault;
    int_ev[INT_USER]      = user_array_fault;
    int_ev[INT_INTEGRITY] = integ.mismatch;
    int_ev[INT_TEMP]      = over_temp || under_temp;
    int_ev[INT_NV_DONE]   = nv_done;
    int_ev[INT_SUPPLY]    = supply_any;
    int_clr = '0;
    if (wr_en && pstrb[0] && hit(paddr, IDX_INT_STATUS)) begin
      int_clr = pwdata[INT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_q <= '0;
    end else begin
      int_status_q <= (int_status_q & ~int_clr) | int_ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_q <= '0;
    end else if (wr_en && pstrb[0] && hit(paddr, IDX_INT_MASK)) begin
      int_mask_q <= pwdata[INT_W-1:0];
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq                   <= 1'b0;
      mem_temp_summary_flag <= 1'b0;
    end else begin
      irq                   <= |(int_status_q & int_mask_q);
      mem_temp_summary_flag <= |memtemp_q;
    end
  end

endmodule : memory_temp_fault_status

/* memory_temp_fault_status_checker.sv */
// concurrent checks on the memory and temperature fault status block
// assumes only the top module's ports are visible; bound at the foot
`timescale 1ns/10ps
module memory_temp_fault_status_checker
  import mtf_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [ADDR_W-1:0]   paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [3:0]          pstrb,
  input wire logic                pready,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  input wire logic                factory_array_fault,
  input wire logic                user_array_fault,
  input wire logic                over_temp,
  input wire logic                under_temp,
  input wire logic                mem_temp_summary_flag
);
  // ==========================================================
  // helpers
  logic rd_mem;
  logic nv_go;
  logic no_ev;
  assign rd_mem = psel && penable && pready && !pwrite && paddr[9:2] == IDX_MEMTEMP;
  assign nv_go  = psel && penable && pready && pwrite && paddr[9:2] == IDX_CONTROL && pwdata[2] && pstrb[0];
  assign no_ev  = !factory_array_fault && !user_array_fault && !over_temp && !under_temp;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // assertions
  AST_FACTORY_SUMMARY: assert property (factory_array_fault |-> ##2 mem_temp_summary_flag)
    else $error("factory fault not summarised");
  AST_USER_SUMMARY: assert property (user_array_fault |-> ##2 mem_temp_summary_flag)
    else $error("user fault not summarised");
  AST_TEMP_SUMMARY: assert property ((over_temp || under_temp) |-> ##2 mem_temp_summary_flag)
    else $error("temperature fault not summarised");
  AST_RESERVED_ZERO: assert property (rd_mem |-> prdata[31:8] == 24'h0 && !prdata[3] && prdata[1:0] == 2'h0)
    else $error("reserved bits read nonzero");
  AST_SUMMARY_MATCH: assert property (rd_mem |-> mem_temp_summary_flag == (|prdata[7:0]))
    else $error("summary differs from register");
  AST_READ_CLEARS: assert property (rd_mem && prdata[5:4] == 2'h0 && no_ev |-> ##2 !mem_temp_summary_flag)
    else $error("read did not clear sticky faults");
  AST_NV_BUSY: assert property (nv_go |-> ##2 mem_temp_summary_flag [*4])
    else $error("busy not held during write");
  AST_PREADY_PULSE: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single cycle");

  COV_INTEGRITY: cover property (rd_mem && prdata[5]);
  COV_NV: cover property (nv_go);
  COV_SLVERR: cover property (pready && pslverr);
endmodule : memory_temp_fault_status_checker

bind memory_temp_fault_status memory_temp_fault_status_checker #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .factory_array_fault(factory_array_fault), .user_array_fault(user_array_fault),
  .over_temp(over_temp), .under_temp(under_temp), .mem_temp_summary_flag(mem_temp_summary_flag));

/* tb_memory_temp_fault_status.sv */
// self-checking bench for the memory and temperature fault status block
// assumes short nv and recovery counts; the master waits for pready until the 5000-cycle watchdog ends the run
`timescale 1ns/10ps
module tb_memory_temp_fault_status
  import mtf_pkg::*;
;
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [9:0]          paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                factory_array_fault;
  logic                user_array_fault;
  logic                over_temp;
  logic                under_temp;
  logic [SUPPLY_W-1:0] supply_fault_in;
  logic                frame_sent;
  logic [7:0]          frame_fault_field;
  logic                mem_temp_summary_flag;
  logic                irq;
  int                  errors;
  int                  checks;
  int                  exp_mem;
  logic [31:0]         seed;
  logic [31:0]         d;
  logic                e;

  memory_temp_fault_status #(.NV_CYCLES(4), .RECOVERY_CYCLES(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .factory_array_fault(factory_array_fault), .user_array_fault(user_array_fault),
    .over_temp(over_temp), .under_temp(under_temp), .supply_fault_in(supply_fault_in),
    .frame_sent(frame_sent), .frame_fault_field(frame_fault_field),
    .mem_temp_summary_flag(mem_temp_summary_flag), .irq(irq));

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  // ==========================================================
  // shared tasks
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'h0};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd_mem;
    apb(1'b0, IDX_MEMTEMP, 32'h0);
    chk(d, exp_mem);
    exp_mem = exp_mem & 32'h1B;
  endtask : rd_mem

  task automatic fire(input logic [3:0] ev);
    {under_temp, over_temp, user_array_fault, factory_array_fault} <= ev;
    @(posedge pclk);
    {under_temp, over_temp, user_array_fault, factory_array_fault} <= 4'h0;
    @(posedge pclk);
  endtask : fire

  task automatic rst;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    exp_mem = 0;
  endtask : rst

  // ==========================================================
  // scenarios
  initial begin
    int memb [4] = '{32'h80, 32'h40, 32'h04, 32'h04};
    int intb [4] = '{32'h01, 32'h02, 32'h08, 32'h08};
    errors = 0; checks = 0; seed = 32'h50BC;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 10'h000;
    pwdata  <= 32'h0000_0000;
    {under_temp, over_temp, user_array_fault, factory_array_fault} <= 4'h0;
    supply_fault_in <= '0; frame_sent <= 1'b0; frame_fault_field <= 8'h00;
    rst;
    rd_mem;
    apb(1'b0, IDX_MAIN_STATUS, 32'h0); chk(d, 32'h0);
    apb(1'b1, IDX_INT_MASK, 32'h3F);
    for (int k = 0; k < 4; k++) begin
      fire(4'h1 << k);
      exp_mem = exp_mem | memb[k];
      @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      rd_mem;
      rd_mem;
      apb(1'b0, IDX_INT_STATUS, 32'h0); chk(d, intb[k]);
      apb(1'b1, IDX_INT_STATUS, 32'h3F);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
    end
    fire(4'h3);
    frame_sent <= 1'b1; frame_fault_field <= 8'h80;
    @(posedge pclk);
    frame_sent <= 1'b0;
    @(posedge pclk);
    exp_mem = 32'h40;
    rd_mem;
    over_temp <= 1'b1;
    repeat (2) @(posedge pclk);
    exp_mem = 32'h04;
    rd_mem;
    exp_mem = 32'h04;
    rd_mem;
    over_temp <= 1'b0;
    repeat (2) @(posedge pclk);
    exp_mem = 32'h04;
    rd_mem;
    rd_mem;
    apb(1'b1, IDX_MEMTEMP, 32'hFF);
    rd_mem;
    apb(1'b0, 8'h3F, 32'h0);
    chk(d, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, IDX_INT_STATUS, 32'h3F);
    apb(1'b1, IDX_CONTROL, 32'h4);
    exp_mem = 32'h10;
    rd_mem;
    repeat (8) @(posedge pclk);
    exp_mem = 0;
    rd_mem;
    apb(1'b0, IDX_INT_STATUS, 32'h0); chk(d, 32'h10);
    apb(1'b1, IDX_CONTROL, 32'h2);
    seed = xs(seed);
    supply_fault_in <= seed[4:0] | 5'h01;
    @(posedge pclk);
    supply_fault_in <= '0;
    @(posedge pclk);
    apb(1'b0, IDX_SUPPLY_STATUS, 32'h0);
    chk(d, {seed[4], 3'h0, seed[3:1], 1'b1});
    repeat (20) @(posedge pclk);
    apb(1'b0, IDX_SUPPLY_STATUS, 32'h0);
    chk(d, 32'h0);
    // report-off cleared: flags outlive the timer until a read
    apb(1'b1, IDX_CONTROL, 32'h0);
    supply_fault_in <= 5'h10;
    @(posedge pclk);
    supply_fault_in <= '0;
    repeat (20) @(posedge pclk);
    apb(1'b0, IDX_SUPPLY_STATUS, 32'h0);
    chk(d, 32'h80);
    apb(1'b0, IDX_SUPPLY_STATUS, 32'h0);
    chk(d, 32'h0);
    seed = xs(seed);
    apb(1'b1, IDX_USER_BASE, {24'h0, seed[7:0] | 8'h01});
    repeat (4) @(posedge pclk);
    rd_mem;
    apb(1'b1, IDX_CONTROL, 32'h3);
    repeat (4) @(posedge pclk);
    apb(1'b1, IDX_USER_BASE + 8'h01, {24'h0, seed[15:8] | 8'h01});
    repeat (4) @(posedge pclk);
    exp_mem = 32'h20;
    rd_mem;
    exp_mem = 32'h20;
    rd_mem;
    rst;
    rd_mem;
    tally_and_finish;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    tally_and_finish;
  end
endmodule : tb_memory_temp_fault_status
